/* pkg/arop_cfg.svh */
`ifndef AROP_CFG_SVH
`define AROP_CFG_SVH

`define AROP_WORD_W        16
`define AROP_FIFO_DEPTH    16
`define AROP_LVL_W         5
`define AROP_LVL_ONE       5'h01
`define AROP_RESULT_RST    16'h0000

// synchronised pin bundle, bit positions
`define AROP_SYNC_W        8
`define AROP_SY_CS         0
`define AROP_SY_RD         1
`define AROP_SY_SCLK       2
`define AROP_SY_SEL        3
`define AROP_SY_SRC        4
`define AROP_SY_INV        5
`define AROP_SY_POL        6
`define AROP_SY_RST        7

// shared pin positions on the data bus
`define AROP_POS_SDO       8
`define AROP_POS_SCLK      9
`define AROP_POS_SYNC      10
`define AROP_POS_FLAG      11

// serial frame and internal clock timing
`define AROP_BIT_CNT_W     5
`define AROP_LAST_BIT      5'h10
`define AROP_CLK_PERIOD_NS 100
`define AROP_SCLK_HALF_NS  500
`define AROP_SCLK_HALF_CYC \
    ((`AROP_SCLK_HALF_NS + `AROP_CLK_PERIOD_NS - 1) / `AROP_CLK_PERIOD_NS)
`define AROP_DIV_W         4
`define AROP_DIV_RST       4'h0

`endif

/* pkg/arop_pkg.sv */
package arop_pkg;

    typedef enum logic {
        st_idle,
        st_shift
    } arop_state_type;

endpackage : arop_pkg

/* verilog/arop_sync.sv */
module arop_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  logic         clk,
    input  logic         arst_n,
    // pins in, synchronised out
    input  logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // first stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= d_in[i];
                    sync_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign q_out = sync_reg;

endmodule : arop_sync

/* verilog/arop_fifo.sv */
module arop_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  logic                       clk,
    input  logic                       arst_n,
    input  logic                       flush,
    // fill side
    input  logic                       in_valid,
    output logic                       in_ready,
    input  logic [W-1:0]               in_data,
    // drain side
    output logic                       out_valid,
    input  logic                       out_ready,
    output logic [W-1:0]               out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);

    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW-1:0] rd_ptr_next;
    logic [LW-1:0] cnt_reg;
    logic [LW-1:0] cnt_next;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_reg != LW'(DEPTH)) && !flush;
    assign out_valid = (cnt_reg != '0) && !flush;
    assign out_data  = mem[rd_ptr_reg];
    assign level     = cnt_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        cnt_next    = cnt_reg;
        if (push) begin
            wr_ptr_next = AW'(wr_ptr_reg + 1'b1);
        end
        if (pop) begin
            rd_ptr_next = AW'(rd_ptr_reg + 1'b1);
        end
        if (push && !pop) begin
            cnt_next = LW'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = LW'(cnt_reg - 1'b1);
        end
        if (flush) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
            cnt_next    = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            cnt_reg    <= cnt_next;
        end
    end

    // storage carries no reset; only written words are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

endmodule : arop_fifo

/* verilog/arop_top.sv */
`include "arop_cfg.svh"

module arop_top (
    // clock and reset
    input  logic                    clk,
    input  logic                    arst_n,
    // converter core side
    input  logic                    conv_start,
    input  logic                    res_valid,
    output logic                    res_ready,
    input  logic [`AROP_WORD_W-1:0] res_data,
    output logic                    conv_abort,
    output logic                    busy,
    // host control pins
    input  logic                    cs_n,
    input  logic                    rd_n,
    input  logic                    reset_pin,
    input  logic                    interface_select,
    input  logic                    clock_source_select,
    input  logic                    clock_invert_select,
    input  logic                    frame_sync_polarity_select,
    input  logic                    sclk_i,
    // data bus pins
    output logic [`AROP_WORD_W-1:0] data_o,
    output logic [`AROP_WORD_W-1:0] data_oe
);

    logic [`AROP_SYNC_W-1:0]    pin_s;
    logic                       cs_act;
    logic                       bus_en;
    logic                       ser;
    logic                       ext;
    logic                       inv;
    logic                       pol;
    logic                       rst_pin;

    logic                       fifo_valid;
    logic [`AROP_WORD_W-1:0]    fifo_data;
    logic [`AROP_LVL_W-1:0]     fifo_level;
    logic                       load;
    logic                       push;

    arop_pkg::arop_state_type   state_reg;
    arop_pkg::arop_state_type   state_next;
    logic [`AROP_WORD_W-1:0]    sr_reg;
    logic [`AROP_WORD_W-1:0]    sr_next;
    logic                       sr_valid_reg;
    logic                       sr_valid_next;
    logic [`AROP_WORD_W-1:0]    par_reg;
    logic [`AROP_WORD_W-1:0]    par_next;
    logic                       sdo_reg;
    logic                       sdo_next;
    logic [`AROP_BIT_CNT_W-1:0] cnt_reg;
    logic [`AROP_BIT_CNT_W-1:0] cnt_next;
    logic [`AROP_DIV_W-1:0]     div_reg;
    logic [`AROP_DIV_W-1:0]     div_next;
    logic                       base_reg;
    logic                       base_next;
    logic                       flag_reg;
    logic                       flag_next;
    logic                       busy_reg;
    logic                       busy_next;
    logic                       conv_act_reg;
    logic                       conv_act_next;
    logic                       abort_reg;
    logic                       sclk_d_reg;

    logic                       ext_rise;
    logic                       ext_fall;
    logic                       int_tick;
    logic                       upd;
    logic                       smp;
    logic                       start_int;
    logic                       start_ext;
    logic                       rd_err;

    arop_sync #(
        .W (`AROP_SYNC_W)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d_in   ({reset_pin, frame_sync_polarity_select,
                  clock_invert_select, clock_source_select,
                  interface_select, sclk_i, rd_n, cs_n}),
        .q_out  (pin_s)
    );

    // results queue up while the host is slow; full stalls the core
    arop_fifo #(
        .W     (`AROP_WORD_W),
        .DEPTH (`AROP_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .flush     (rst_pin),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .in_data   (res_data),
        .out_valid (fifo_valid),
        .out_ready (load),
        .out_data  (fifo_data),
        .level     (fifo_level)
    );

    always_comb begin
        cs_act  = !pin_s[`AROP_SY_CS];
        bus_en  = cs_act && !pin_s[`AROP_SY_RD];
        ser     = pin_s[`AROP_SY_SEL];
        ext     = pin_s[`AROP_SY_SRC];
        inv     = pin_s[`AROP_SY_INV];
        pol     = pin_s[`AROP_SY_POL];
        rst_pin = pin_s[`AROP_SY_RST];
    end

    // edges of the outside clock count only under chip select
    assign ext_rise = pin_s[`AROP_SY_SCLK] && !sclk_d_reg && cs_act;
    assign ext_fall = !pin_s[`AROP_SY_SCLK] && sclk_d_reg && cs_act;
    assign int_tick = (state_reg == arop_pkg::st_shift) && !ext &&
                      (div_reg == `AROP_DIV_W'(`AROP_SCLK_HALF_CYC - 1));

    // update edge follows the invert select
    always_comb begin
        if (ext) begin
            upd = inv ? ext_fall : ext_rise;
            smp = inv ? ext_rise : ext_fall;
        end else begin
            upd = int_tick && !base_reg;
            smp = int_tick && base_reg;
        end
    end

    assign push      = res_valid && res_ready;
    assign start_int = ser && !ext && bus_en && sr_valid_reg &&
                       (state_reg == arop_pkg::st_idle);
    assign start_ext = ser && ext && upd && sr_valid_reg;
    assign rd_err    = ser && ext && push;
    assign load      = fifo_valid && !rst_pin &&
                       (state_reg == arop_pkg::st_idle) &&
                       (!sr_valid_reg || !ser);

    always_comb begin
        state_next    = state_reg;
        sr_next       = sr_reg;
        sr_valid_next = sr_valid_reg;
        par_next      = par_reg;
        sdo_next      = sdo_reg;
        cnt_next      = cnt_reg;
        div_next      = div_reg;
        base_next     = base_reg;
        flag_next     = 1'b0;
        conv_act_next = conv_act_reg;
        busy_next     = busy_reg;
        if ((state_reg == arop_pkg::st_shift) && !ext) begin
            div_next  = int_tick ? `AROP_DIV_RST : div_reg + 1'b1;
            base_next = int_tick ? !base_reg : base_reg;
        end
        case (state_reg)
            arop_pkg::st_idle: begin
                if (load) begin
                    sr_next       = fifo_data;
                    par_next      = fifo_data;
                    sr_valid_next = 1'b1;
                end else if (start_int) begin
                    state_next = arop_pkg::st_shift;
                    div_next   = `AROP_DIV_RST;
                    base_next  = 1'b0;
                    cnt_next   = '0;
                end else if (start_ext) begin
                    // first outside edge is already the first update
                    state_next = arop_pkg::st_shift;
                    sdo_next   = sr_reg[`AROP_WORD_W-1];
                    sr_next    = {sr_reg[`AROP_WORD_W-2:0], 1'b0};
                    cnt_next   = `AROP_BIT_CNT_W'(1);
                end
            end
            arop_pkg::st_shift: begin
                if (rd_err) begin
                    // unread word is lost; the fresh one loads next
                    state_next    = arop_pkg::st_idle;
                    sr_valid_next = 1'b0;
                    flag_next     = 1'b1;
                end else if (upd && (cnt_reg != `AROP_LAST_BIT)) begin
                    sdo_next = sr_reg[`AROP_WORD_W-1];
                    sr_next  = {sr_reg[`AROP_WORD_W-2:0], 1'b0};
                    cnt_next = cnt_reg + 1'b1;
                end else if (smp && (cnt_reg == `AROP_LAST_BIT)) begin
                    state_next    = arop_pkg::st_idle;
                    sr_valid_next = 1'b0;
                    base_next     = 1'b0;
                    div_next      = `AROP_DIV_RST;
                end
            end
            default: begin
                state_next = arop_pkg::st_idle;
            end
        endcase
        // busy holds until the last queued result reaches the register
        if (conv_start) begin
            conv_act_next = 1'b1;
            busy_next     = 1'b1;
        end else begin
            if (push) begin
                conv_act_next = 1'b0;
            end
            if (load && !conv_act_reg && !push &&
                (fifo_level == `AROP_LVL_ONE)) begin
                busy_next = 1'b0;
            end
        end
        if (rst_pin) begin
            // synchronous return to reset state
            state_next    = arop_pkg::st_idle;
            sr_next       = `AROP_RESULT_RST;
            sr_valid_next = 1'b0;
            par_next      = `AROP_RESULT_RST;
            sdo_next      = 1'b0;
            cnt_next      = '0;
            div_next      = `AROP_DIV_RST;
            base_next     = 1'b0;
            flag_next     = 1'b0;
            conv_act_next = 1'b0;
            busy_next     = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg    <= arop_pkg::st_idle;
            sr_reg       <= `AROP_RESULT_RST;
            sr_valid_reg <= 1'b0;
            par_reg      <= `AROP_RESULT_RST;
            sdo_reg      <= 1'b0;
            cnt_reg      <= '0;
            div_reg      <= `AROP_DIV_RST;
            base_reg     <= 1'b0;
            flag_reg     <= 1'b0;
            conv_act_reg <= 1'b0;
            busy_reg     <= 1'b0;
            abort_reg    <= 1'b0;
            sclk_d_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            sr_reg       <= sr_next;
            sr_valid_reg <= sr_valid_next;
            par_reg      <= par_next;
            sdo_reg      <= sdo_next;
            cnt_reg      <= cnt_next;
            div_reg      <= div_next;
            base_reg     <= base_next;
            flag_reg     <= flag_next;
            conv_act_reg <= conv_act_next;
            busy_reg     <= busy_next;
            abort_reg    <= rst_pin;
            sclk_d_reg   <= pin_s[`AROP_SY_SCLK];
        end
    end

    assign busy       = busy_reg;
    assign conv_abort = abort_reg;

    // pin mux from registered state only, so the pads never glitch on logic
    always_comb begin
        data_o  = par_reg;
        data_oe = {`AROP_WORD_W{bus_en}};
        if (ser) begin
            data_o[7:0]                = '0;
            data_oe[7:0]               = '0;
            data_o[`AROP_POS_SDO]      = sdo_reg;
            data_o[`AROP_POS_SCLK]     = base_reg ^ inv;
            data_oe[`AROP_POS_SCLK]    = bus_en && !ext;
            data_o[`AROP_POS_SYNC]     =
                ((state_reg == arop_pkg::st_shift) && !ext) ^ pol;
            data_o[`AROP_POS_FLAG]     = ext && flag_reg;
        end
    end

    property p_upd_rise;
        @(posedge clk) disable iff (!arst_n)
        (ser && !ext && !inv && upd) |=> $rose(data_o[`AROP_POS_SCLK]);
    endproperty
    a_upd_rise: assert property (p_upd_rise)
        else $error("data update not on rising serial clock");

    property p_upd_fall;
        @(posedge clk) disable iff (!arst_n)
        (ser && !ext && inv && upd) |=> $fell(data_o[`AROP_POS_SCLK]);
    endproperty
    a_upd_fall: assert property (p_upd_fall)
        else $error("data update not on falling serial clock");

    property p_par_bits;
        @(posedge clk) disable iff (!arst_n)
        (load && !ser && $stable(ser)) |=>
            (data_o[11:9] == $past(fifo_data[11:9]));
    endproperty
    a_par_bits: assert property (p_par_bits)
        else $error("shared pins do not carry result bits 9 to 11");

    property p_ext_clk_in;
        @(posedge clk) disable iff (!arst_n)
        (ser && ext) |-> !data_oe[`AROP_POS_SCLK];
    endproperty
    a_ext_clk_in: assert property (p_ext_clk_in)
        else $error("serial clock driven while external source chosen");

    property p_sync_high;
        @(posedge clk) disable iff (!arst_n)
        (start_int && !pol && !rst_pin && $stable(pol)) |=>
            data_o[`AROP_POS_SYNC] [*3];
    endproperty
    a_sync_high: assert property (p_sync_high)
        else $error("frame sync not high at read start");

    property p_sync_low;
        @(posedge clk) disable iff (!arst_n)
        (start_int && pol && !rst_pin && $stable(pol)) |=>
            !data_o[`AROP_POS_SYNC] [*3];
    endproperty
    a_sync_low: assert property (p_sync_low)
        else $error("frame sync not low at read start");

    property p_rd_err;
        @(posedge clk) disable iff (!arst_n)
        (state_reg == arop_pkg::st_shift && rd_err && !rst_pin &&
         $stable(ext)) |=> (data_o[`AROP_POS_FLAG] && !sr_valid_reg) ##1
            !flag_reg;
    endproperty
    a_rd_err: assert property (p_rd_err)
        else $error("incomplete read not flagged for one cycle");

    property p_upper_out;
        @(posedge clk) disable iff (!arst_n)
        bus_en |-> (data_oe[15:12] == 4'hf);
    endproperty
    a_upper_out: assert property (p_upper_out)
        else $error("upper result bits not driven");

    property p_busy_rise;
        @(posedge clk) disable iff (!arst_n)
        (conv_start && !rst_pin) |=> busy [*2];
    endproperty
    a_busy_rise: assert property (p_busy_rise)
        else $error("busy did not rise at conversion start");

    property p_busy_fall;
        @(posedge clk) disable iff (!arst_n)
        $fell(busy) |-> ($past(load) || $past(rst_pin));
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("busy fell before result was latched");

    property p_oe_gate;
        @(posedge clk) disable iff (!arst_n)
        (data_oe != '0) |-> (!pin_s[`AROP_SY_CS] && !pin_s[`AROP_SY_RD]);
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("outputs enabled without chip select and read");

    property p_cs_gate;
        @(posedge clk) disable iff (!arst_n)
        (ext && pin_s[`AROP_SY_CS] && state_reg == arop_pkg::st_shift &&
         !rst_pin) |=> $stable(sdo_reg) && $stable(cnt_reg);
    endproperty
    a_cs_gate: assert property (p_cs_gate)
        else $error("outside clock acted without chip select");

    property p_reset_pin;
        @(posedge clk) disable iff (!arst_n)
        rst_pin |=> (state_reg == arop_pkg::st_idle) && !busy &&
            conv_abort && (fifo_level == '0);
    endproperty
    a_reset_pin: assert property (p_reset_pin)
        else $error("reset pin did not restore reset state");

    c_int_frame: cover property (@(posedge clk) disable iff (!arst_n)
        !ext && smp && (cnt_reg == `AROP_LAST_BIT));
    c_ext_frame: cover property (@(posedge clk) disable iff (!arst_n)
        ext && smp && (cnt_reg == `AROP_LAST_BIT));
    c_rd_err: cover property (@(posedge clk) disable iff (!arst_n)
        data_o[`AROP_POS_FLAG] && ser);
    c_fifo_full: cover property (@(posedge clk) disable iff (!arst_n)
        !res_ready && !rst_pin);

endmodule : arop_top

/* sim/arop_host_model.sv */
module arop_host_model (
    // clock
    input  logic        clk,
    // pins seen from the host
    input  logic [15:0] data_o,
    output logic        sclk_i
);
    timeunit 1ns;
    timeprecision 1ns;

    // the clock stands still between frames at its sample level
    initial sclk_i = 1'b0;

    task automatic idle(input logic inv);
        @(posedge clk) sclk_i <= inv;
    endtask : idle

    // 800 ns link period; data sampled just before the return edge
    task automatic read_ext(input logic inv, input int nb,
                            output logic [15:0] v);
        v = 16'h0000;
        for (int k = 0; k < nb; k++) begin
            @(posedge clk) sclk_i <= ~inv;
            repeat (3) @(posedge clk);
            @(negedge clk) v = {v[14:0], data_o[8]};
            @(posedge clk) sclk_i <= inv;
            repeat (3) @(posedge clk);
        end
    endtask : read_ext

    // internal clock: collect a bit at each falling edge of the base clock
    task automatic read_int(input logic inv, input logic pol,
                            output logic [15:0] v, output int nb,
                            output int bad);
        logic prv;
        logic cur;
        logic pd;
        logic ps;
        prv = 1'b0;
        pd = 1'b0;
        ps = 1'b0;
        nb = 0;
        bad = 0;
        v = 16'h0000;
        for (int c = 0; c < 400 && nb < 16; c++) begin
            @(negedge clk);
            cur = data_o[9] ^ inv;
            // a real host latches what stood just before the sample edge
            if (prv && !cur) begin
                v = {v[14:0], pd};
                nb++;
                if (ps !== ~pol) bad++;
            end
            prv = cur;
            pd = data_o[8];
            ps = data_o[10];
        end
    endtask : read_int
endmodule : arop_host_model

/* sim/adc_result_output_port_bench.sv */
module adc_result_output_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, arst_n, conv_start, res_valid, res_ready, busy;
    logic        conv_abort, cs_n, rd_n, reset_pin, sclk_i;
    logic        interface_select, clock_source_select;
    logic        clock_invert_select, frame_sync_polarity_select;
    logic [15:0] res_data, data_o, data_oe, w, got;
    int          err_count, samples_checked, flags, n, bad;

    arop_top i_dut (.clk(clk), .arst_n(arst_n), .conv_start(conv_start),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data),
        .conv_abort(conv_abort), .busy(busy), .cs_n(cs_n), .rd_n(rd_n),
        .reset_pin(reset_pin), .interface_select(interface_select),
        .clock_source_select(clock_source_select),
        .clock_invert_select(clock_invert_select),
        .frame_sync_polarity_select(frame_sync_polarity_select),
        .sclk_i(sclk_i), .data_o(data_o), .data_oe(data_oe));
    arop_host_model i_host (.clk(clk), .data_o(data_o), .sclk_i(sclk_i));

    always #50 clk = ~clk;
    always @(negedge clk) if (interface_select && data_o[11] === 1'b1) flags++;

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic stop(input string nm);
        err_count++;
        $display("wrong value %s expected done seen timeout", nm);
        final_report();
    endtask : stop

    // inactive frame sync level follows the polarity select
    function automatic logic [15:0] idle_sync(input logic pol);
        return {15'h0000, pol};
    endfunction : idle_sync

    task automatic mode(input logic sel, src, inv, pol);
        @(posedge clk) cs_n <= 1'b1;
        interface_select <= sel;
        clock_source_select <= src;
        clock_invert_select <= inv;
        frame_sync_polarity_select <= pol;
        i_host.idle(inv);
        repeat (4) @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (4) @(posedge clk);
        flags = 0;
    endtask : mode

    task automatic convert(input logic [15:0] v);
        logic ok;
        @(posedge clk) conv_start <= 1'b1;
        @(posedge clk) conv_start <= 1'b0;
        res_valid <= 1'b1;
        res_data <= v;
        ok = 1'b0;
        for (int i = 0; i < 40 && !ok; i++) begin
            @(negedge clk) ok = (res_ready === 1'b1);
            if (i == 0) check("busy", 16'h0001, 16'(busy));
            @(posedge clk);
        end
        res_valid <= 1'b0;
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clk);
        if (!ok || busy !== 1'b0) stop("busy");
        @(posedge clk);
    endtask : convert

    initial begin
        {clk, arst_n, conv_start, res_valid, reset_pin} = 5'h00;
        {cs_n, rd_n, interface_select, clock_source_select} = 4'hc;
        {clock_invert_select, frame_sync_polarity_select} = 2'h0;
        res_data = 16'h0000;
        {err_count, samples_checked, flags} = 0;
        void'($urandom(76212));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        mode(1'b0, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            w = (k == 0) ? 16'hffff : 16'($urandom());
            convert(w);
            check("parallel bus", w, data_o);
            check("parallel enables", 16'hffff, data_oe);
        end
        @(posedge clk) rd_n <= 1'b1;
        repeat (4) @(negedge clk);
        check("released enables", 16'h0000, data_oe);
        @(posedge clk) conv_start <= 1'b1;
        @(posedge clk) conv_start <= 1'b0;
        reset_pin <= 1'b1;
        repeat (5) @(negedge clk);
        check("abort", 16'h0001, 16'(conv_abort));
        check("busy in reset", 16'h0000, 16'(busy));
        check("ready in reset", 16'h0000, 16'(res_ready));
        @(posedge clk) reset_pin <= 1'b0;
        $display("parallel and reset tests done");
        for (int m = 0; m < 4; m++) begin
            mode(1'b1, 1'b0, m[0], m[1]);
            w = (m == 0) ? 16'h8001 : 16'($urandom());
            convert(w);
            check("clock enable", 16'h0001, 16'(data_oe[9]));
            i_host.read_int(m[0], m[1], got, n, bad);
            check("bit count", 16'h0010, 16'(n));
            check("internal word", w, got);
            check("sync misses", 16'h0000, 16'(bad));
            repeat (3) @(negedge clk);
            check("idle sync", idle_sync(m[1]), 16'(data_o[10]));
        end
        $display("internal clock tests done");
        for (int m = 0; m < 2; m++) begin
            mode(1'b1, 1'b1, m[0], 1'b0);
            w = 16'($urandom());
            convert(w);
            check("clock input", 16'h0000, 16'(data_oe[9]));
            check("ext sync", idle_sync(1'b0), 16'(data_o[10]));
            @(posedge clk) cs_n <= 1'b1;
            i_host.read_ext(m[0], 16, got);
            @(posedge clk) cs_n <= 1'b0;
            repeat (4) @(posedge clk);
            i_host.read_ext(m[0], 16, got);
            check("external word", w, got);
        end
        w = 16'($urandom());
        convert(w);
        i_host.read_ext(1'b1, 5, got);
        check("partial word", {11'h000, w[15:11]}, got);
        @(posedge clk) cs_n <= 1'b1;
        i_host.read_ext(1'b1, 2, got);
        @(posedge clk) cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        i_host.read_ext(1'b1, 3, got);
        check("resumed bits", {13'h0000, w[10:8]}, got);
        w = 16'($urandom());
        convert(w);
        check("error pulses", 16'h0001, 16'(flags));
        i_host.read_ext(1'b1, 16, got);
        check("word after error", w, got);
        $display("external clock tests done");
        final_report();
    end
endmodule : adc_result_output_port_bench
